//--- shared/rrc_defines.svh
/*
 * constants of the root/context entry decoder: field positions, register
 * offsets, reset values and timing counts.
 * assumes nothing; included by its bare name wherever needed.
 */
`ifndef RRC_DEFINES_SVH
`define RRC_DEFINES_SVH

// scalable-mode root entry fields
`define RRC_UPPER_CTX_TABLE_BASE_HI        127
`define RRC_UPPER_CTX_TABLE_BASE_LO        76
`define RRC_UP_BIT         64
`define RRC_LOWER_CTX_TABLE_BASE_HI        63
`define RRC_LOWER_CTX_TABLE_BASE_LO        12
`define RRC_LP_BIT         0
`define RRC_PAGE_SHIFT     12

// legacy context entry fields
`define RRC_DTAG_HI        87
`define RRC_DTAG_LO        72
`define RRC_CTX_PRESENT    0
`define RRC_CTX_FPD        1

// table mode encodings
`define RRC_TM_LEGACY      2'h0
`define RRC_TM_SCALABLE    2'h1

// register byte offsets
`define RRC_REG_CTRL       12'h000
`define RRC_REG_CAP        12'h004
`define RRC_REG_REQ        12'h008
`define RRC_REG_ENT0       12'h010
`define RRC_REG_ENT1       12'h014
`define RRC_REG_ENT2       12'h018
`define RRC_REG_ENT3       12'h01C
`define RRC_REG_STAT       12'h020
`define RRC_REG_BASE_LO    12'h024
`define RRC_REG_BASE_HI    12'h028
`define RRC_REG_TAG        12'h02C

// ctrl register fields
`define RRC_CTRL_TM_LO     0
`define RRC_CTRL_GO        4
`define RRC_CTRL_CTX       5
`define RRC_CTRL_RESET     32'h0000_0000

// capability register fields
`define RRC_CAP_DW_LO      0
`define RRC_CAP_CM         8

// request register fields
`define RRC_REQ_DEVFN_LO   0
`define RRC_REQ_PASID      8

// timing: decode latency of one cycle
`define RRC_DECODE_CYCLES  1

`endif

//--- shared/rrc_pkg.sv
/*
 * types of the root/context entry decoder.
 * assumes rrc_defines.svh for numeric constants.
 */
package rrc_pkg;

    typedef enum logic [1:0] {
        RRC_OK,
        RRC_FAULT_ROOT,
        RRC_FAULT_CTX,
        RRC_FAULT_PASID
    } rrc_result_t;

    typedef enum {
        RRC_IDLE,
        RRC_DECODE,
        RRC_DONE
    } rrc_state_t;

endpackage

//--- shared/rrc_entry_if.sv
/*
 * carrier between the decoder core and its entry-field extractor.
 * assumes one core clock; purely combinational signals.
 */
`timescale 1ns/1ps
interface rrc_entry_if #(parameter int HOST_ADDR_WIDTH = 48, parameter int DW = 16);
    logic [127:0] entry;
    logic         ctx_mode;
    logic [7:0]   devfn;
    logic         upper_half_valid;
    logic         lower_half_valid;
    logic [63:0]  upper_ctx_table_base;
    logic [63:0]  lower_ctx_table_base;
    logic         ctx_present;
    logic         ctx_fault_off;
    logic [15:0]  domain_tag;

    modport core (output entry, output ctx_mode, output devfn,
                  input upper_half_valid, input lower_half_valid,
                  input upper_ctx_table_base, input lower_ctx_table_base,
                  input ctx_present, input ctx_fault_off, input domain_tag);
    modport fields (input entry, input ctx_mode, input devfn,
                    output upper_half_valid, output lower_half_valid,
                    output upper_ctx_table_base, output lower_ctx_table_base,
                    output ctx_present, output ctx_fault_off, output domain_tag);
endinterface

//--- rtl/rrc_fields.sv
/*
 * field extractor: splits a fetched 128-bit entry into pointers, valid bits
 * and domain tag, masking bits that the host address width reserves.
 * assumes the entry was fetched as one whole 128-bit word.
 */
`timescale 1ns/1ps
`include "rrc_defines.svh"
module rrc_fields #(
    parameter int HOST_ADDR_WIDTH = 48,
    parameter int DW  = 16
) (
    // entry side
    rrc_entry_if.fields ef
);
    // pointer bits at or above the host address width read as zero
    localparam logic [63:0] ADDR_MASK = (64'h0000_0000_0000_0001 << HOST_ADDR_WIDTH) - 64'h0000_0000_0000_0001;
    localparam logic [15:0] TAG_MASK  = 16'(((32'h0000_0001) << DW) - 32'h0000_0001);

    logic [63:0] upper_raw;
    logic [63:0] lower_raw;
    logic [63:0] idx_off;

    // raw pointers widened back to byte addresses
    always_comb begin
        upper_raw = {ef.entry[`RRC_UPPER_CTX_TABLE_BASE_HI:`RRC_UPPER_CTX_TABLE_BASE_LO], 12'h000};
        lower_raw = {ef.entry[`RRC_LOWER_CTX_TABLE_BASE_HI:`RRC_LOWER_CTX_TABLE_BASE_LO], 12'h000};
        idx_off   = {52'h0_0000_0000_0000, ef.devfn, 4'h0};
    end

    // valid bits gate everything else in their half, so an absent half yields 0
    assign ef.upper_half_valid     = ef.entry[`RRC_UP_BIT];
    assign ef.lower_half_valid     = ef.entry[`RRC_LP_BIT];
    assign ef.upper_ctx_table_base = ef.upper_half_valid ?
                                     ((upper_raw & ADDR_MASK) | idx_off) : 64'h0;
    assign ef.lower_ctx_table_base = ef.lower_half_valid ?
                                     ((lower_raw & ADDR_MASK) | idx_off) : 64'h0;

    // legacy context entry: present bit, fault-disable and domain tag
    assign ef.ctx_present   = ef.entry[`RRC_CTX_PRESENT];
    assign ef.ctx_fault_off = ef.entry[`RRC_CTX_FPD];
    assign ef.domain_tag    = ef.ctx_present ?
                              (ef.entry[`RRC_DTAG_HI:`RRC_DTAG_LO] & TAG_MASK) : 16'h0;
endmodule

//--- rtl/rrc_decoder.sv
/*
 * root/context entry decoder with an apb register file. software loads a
 * 128-bit entry and a request, sets go, and reads the decoded base, domain
 * tag and fault result.
 * assumes an apb master on core_clk, entries written whole before go.
 */
// Notes on behaviour
// - upper pointer is bits 127:76, 4KB aligned
// - upper bits from 64+width reserved zero
// - upper valid bit gates bits 127:65
// - lower pointer is bits 63:12, 4KB aligned
// - lower bits from address width reserved zero
// - lower valid bit gates bits 63:1
// - legacy context only for requests without pasid
// - domain tag from context bits 87:72
// - supported domain tag width is reported
// - unused upper domain tag bits reserved
// - scalable format only when mode is 01b
// - each entry is taken as one word
// - absent context ignores all but fault-disable
`timescale 1ns/1ps
`include "rrc_defines.svh"
module rrc_decoder #(
    parameter int HOST_ADDR_WIDTH = 48,
    parameter int DW  = 16,
    parameter bit CM  = 1'b0
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // status
    output logic             fault,
    output logic             busy
);
    initial begin
        if (HOST_ADDR_WIDTH < 13 || HOST_ADDR_WIDTH > 64 || DW < 1 || DW > 16) begin
            $error("rrc_decoder: unsupported HOST_ADDR_WIDTH or DW");
        end
    end

    typedef struct packed {
        logic [1:0]          table_mode_select;
        logic                ctx_mode;
        logic [7:0]          devfn;
        logic                has_pasid;
        logic [127:0]        entry;
        rrc_pkg::rrc_state_t state;
        rrc_pkg::rrc_result_t result;
        logic                done;
        logic                fault_off;
        logic [63:0]         base;
        logic [15:0]         domain_tag;
        logic [31:0]         prdata;
        logic                pslverr;
        logic                ack;
    } rrc_state_s_t;

    rrc_state_s_t cur;
    rrc_state_s_t next_cur;

    rrc_entry_if #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH), .DW(DW)) eif ();

    rrc_fields #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH), .DW(DW)) u_fields (
        .ef (eif.fields)
    );

    // the core drives the extractor from the latched entry
    assign eif.entry    = cur.entry;
    assign eif.ctx_mode = cur.ctx_mode;
    assign eif.devfn    = cur.devfn;

    logic        acc;
    logic        wr;
    logic [31:0] wmask;
    logic [31:0] rdata;
    logic        hit;

    // one wait state: read data is loaded into its flop at the same edge where pready rises,
    // so the master finds it standing at the completing edge
    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    assign pready  = cur.ack & clk_en;
    assign prdata  = cur.prdata;
    assign pslverr = cur.pslverr;
    assign fault   = cur.result != rrc_pkg::RRC_OK;
    assign busy    = cur.state != rrc_pkg::RRC_IDLE;
    assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // read mux; reserved bits read zero
    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        unique case (paddr)
            `RRC_REG_CTRL:    rdata = {26'h000_0000, cur.ctx_mode, 3'h0, cur.table_mode_select};
            `RRC_REG_CAP:     rdata = {23'h00_0000, CM, 3'h0, 5'(DW)};
            `RRC_REG_REQ:     rdata = {23'h00_0000, cur.has_pasid, cur.devfn};
            `RRC_REG_ENT0:    rdata = cur.entry[31:0];
            `RRC_REG_ENT1:    rdata = cur.entry[63:32];
            `RRC_REG_ENT2:    rdata = cur.entry[95:64];
            `RRC_REG_ENT3:    rdata = cur.entry[127:96];
            `RRC_REG_STAT:    rdata = {26'h000_0000, cur.fault_off, cur.done,
                                       busy, 1'b0, cur.result};
            `RRC_REG_BASE_LO: rdata = cur.base[31:0];
            `RRC_REG_BASE_HI: rdata = cur.base[63:32];
            `RRC_REG_TAG:     rdata = {16'h0000, cur.domain_tag};
            default:          hit   = 1'b0;
        endcase
    end

    // next-state logic: register writes, then the decode sequence
    always_comb begin
        next_cur = cur;
        // first access cycle: load answer; writes during a decode are refused
        // so the entry stays one atomic word
        if (acc && !cur.ack) begin
            next_cur.ack     = 1'b1;
            next_cur.pslverr = !hit || (pwrite && cur.state != rrc_pkg::RRC_IDLE);
            next_cur.prdata  = pwrite ? 32'h0000_0000 : rdata;
        end
        if (acc && cur.ack) begin
            next_cur.ack = 1'b0;
        end
        // a write lands only at the edge where pready is high
        if (wr && cur.ack && !cur.pslverr && cur.state == rrc_pkg::RRC_IDLE) begin
            unique case (paddr)
                `RRC_REG_CTRL: begin
                    if (pstrb[0]) begin
                        next_cur.table_mode_select = pwdata[`RRC_CTRL_TM_LO +: 2];
                        next_cur.ctx_mode          = pwdata[`RRC_CTRL_CTX];
                    end
                    if (pstrb[0] && pwdata[`RRC_CTRL_GO]) begin
                        next_cur.state = rrc_pkg::RRC_DECODE;
                        next_cur.done  = 1'b0;
                    end
                end
                `RRC_REG_REQ: begin
                    if (pstrb[0]) begin
                        next_cur.devfn = pwdata[7:0];
                    end
                    if (pstrb[1]) begin
                        next_cur.has_pasid = pwdata[`RRC_REQ_PASID];
                    end
                end
                `RRC_REG_ENT0: next_cur.entry[31:0]   = (cur.entry[31:0] & ~wmask) | (pwdata & wmask);
                `RRC_REG_ENT1: next_cur.entry[63:32]  = (cur.entry[63:32] & ~wmask) | (pwdata & wmask);
                `RRC_REG_ENT2: next_cur.entry[95:64]  = (cur.entry[95:64] & ~wmask) | (pwdata & wmask);
                `RRC_REG_ENT3: next_cur.entry[127:96] = (cur.entry[127:96] & ~wmask) | (pwdata & wmask);
                default: ;
            endcase
        end
        unique case (cur.state)
            rrc_pkg::RRC_IDLE: ;
            rrc_pkg::RRC_DECODE: begin
                next_cur.state      = rrc_pkg::RRC_DONE;
                next_cur.base       = 64'h0;
                next_cur.domain_tag = 16'h0;
                next_cur.fault_off  = 1'b0;
                if (cur.table_mode_select == `RRC_TM_SCALABLE && !cur.ctx_mode) begin
                    // devfn bit 7 picks the upper half, the lower otherwise
                    if (cur.devfn[7]) begin
                        if (eif.upper_half_valid) begin
                            next_cur.base   = eif.upper_ctx_table_base;
                            next_cur.result = rrc_pkg::RRC_OK;
                        end else begin
                            next_cur.result = rrc_pkg::RRC_FAULT_ROOT;
                        end
                    end else begin
                        if (eif.lower_half_valid) begin
                            next_cur.base   = eif.lower_ctx_table_base;
                            next_cur.result = rrc_pkg::RRC_OK;
                        end else begin
                            next_cur.result = rrc_pkg::RRC_FAULT_ROOT;
                        end
                    end
                end else if (cur.ctx_mode) begin
                    // legacy context entry: pasid requests fault and take only its fault-disable bit
                    next_cur.fault_off = eif.ctx_fault_off;
                    if (cur.has_pasid) begin
                        next_cur.result = rrc_pkg::RRC_FAULT_PASID;
                    end else if (!eif.ctx_present) begin
                        next_cur.result = rrc_pkg::RRC_FAULT_CTX;
                    end else begin
                        next_cur.domain_tag = eif.domain_tag;
                        next_cur.result     = rrc_pkg::RRC_OK;
                    end
                end else begin
                    // legacy root entry uses the lower pointer and bit 0 only
                    if (eif.lower_half_valid) begin
                        next_cur.base   = eif.lower_ctx_table_base;
                        next_cur.result = rrc_pkg::RRC_OK;
                    end else begin
                        next_cur.result = rrc_pkg::RRC_FAULT_ROOT;
                    end
                end
            end
            rrc_pkg::RRC_DONE: begin
                next_cur.state = rrc_pkg::RRC_IDLE;
                next_cur.done  = 1'b1;
            end
        endcase
    end

    // single state register, frozen while clk_en is low unless rst is high
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur                   <= '0;
            cur.state             <= rrc_pkg::RRC_IDLE;
            cur.result            <= rrc_pkg::RRC_OK;
            cur.table_mode_select <= `RRC_TM_LEGACY;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end
endmodule

//--- verification/rrc_monitor.sv
/*
 * port checker for the root/context entry decoder.
 * assumes clk_en high in the bench; bound to rrc_decoder at the foot.
 */
`timescale 1ns/1ps
module rrc_monitor #(
    parameter int HOST_ADDR_WIDTH = 48,
    parameter int DW  = 16,
    parameter bit CM  = 1'b0
) (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        clk_en,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // status
    input wire logic        fault,
    input wire logic        busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // completed access and go write, decoded once for the properties that use them
    logic acc;
    logic go_wr;
    assign acc   = psel && penable && pready;
    assign go_wr = acc && pwrite && paddr == 12'h000 && pwdata[4];
    a_go_sets_busy: assert property (go_wr && !busy |=> busy)
        else $error("go did not start a decode");
    a_busy_holds: assert property ($rose(busy) |=> busy)
        else $error("decode ended after one cycle");
    a_busy_ends: assert property ($rose(busy) |-> ##[1:3] !busy)
        else $error("decode did not finish in time");
    a_no_stray_busy: assert property (!busy && !go_wr |=> !busy)
        else $error("busy rose without a go write");
    a_fault_holds: assert property (!busy && !$past(busy) |-> $stable(fault))
        else $error("fault changed while idle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    a_ready_waits: assert property (psel && penable && !pready && clk_en |=> pready)
        else $error("ready did not follow the wait state");
    a_cap_value: assert property (acc && !pwrite && paddr == 12'h004
        |-> !pslverr && prdata == {23'h0, CM, 3'h0, 5'(DW)}) else $error("capability wrong");
    a_stat_fault: assert property (acc && !pwrite && paddr == 12'h020 && !busy
        |-> fault == (prdata[1:0] != 2'h0)) else $error("fault disagrees with status");
endmodule
bind rrc_decoder rrc_monitor #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH), .DW(DW), .CM(CM)) u_mon (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault(fault), .busy(busy));

//--- verification/rrc_table_mem.sv
/*
 * table memory as software left it: root and context entries.
 * assumes the bench reads entries by hierarchy and loads them whole.
 */
`timescale 1ns/1ps
module rrc_table_mem;
    logic [127:0] root_ent [2];
    logic [127:0] ctx_ent  [2];
    // fixed reserved ranges zero, root 0 pointer bits above width 40 and tag bits above 8 set; both context entries share tag and table, tag nonzero
    initial begin
        root_ent[0] = {52'hF_0001_2345_6789, 11'h000, 1'b1, 52'hE_0000_0ABC_D123, 11'h000, 1'b1};
        root_ent[1] = {52'h0_0000_0001_2345, 11'h000, 1'b0, 52'h0_0000_0006_7890, 11'h000, 1'b0};
        ctx_ent[0] = {40'h0, 16'hBEEF, 1'b0, 7'h02, 52'h0_0000_0004_5000, 12'h001};
        ctx_ent[1] = {40'h0, 16'hBEEF, 1'b0, 7'h02, 52'h0_0000_0004_5000, 12'h002};
    end
endmodule

//--- verification/test_remap_root_context_entry_decode.sv
/*
 * self-checking bench for the entry decoder over apb.
 * assumes rrc_table_mem supplies entries; host width 40, tag width 8.
 */
`timescale 1ns/1ps
module test_remap_root_context_entry_decode;
    localparam int HAW_T = 40;
    localparam int DW_T  = 8;
    logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, fault, busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int          fails = 0;
    int          num_checks = 0;
    int          cycles = 0;
    rrc_decoder #(.HOST_ADDR_WIDTH(HAW_T), .DW(DW_T), .CM(1'b0)) u_dut (
        .core_clk(core_clk), .rst(rst), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fault(fault), .busy(busy));
    rrc_table_mem u_mem ();
    // 10 MHz clock and hang guard
    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            conclude();
        end
    end
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // answer is read at the negedge where pready is high, half a cycle before the completing edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge core_clk);
        penable <= 1'b1;
        @(negedge core_clk);
        while (pready !== 1'b1) @(negedge core_clk);
        rd  = prdata;
        err = pslverr;
        @(posedge core_clk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic decode(input logic [127:0] e, input logic [31:0] req, input logic [31:0] ctl,
                          output logic [31:0] st, output logic [63:0] b, output logic [31:0] tg);
        logic er;
        for (int i = 0; i < 4; i++) apb(1'b1, 12'h010 + 12'(4 * i), e[32 * i +: 32], tg, er);
        apb(1'b1, 12'h008, req, tg, er);
        apb(1'b1, 12'h000, ctl, tg, er);
        st = 32'h0;
        for (int n = 0; n < 20 && st[4] !== 1'b1; n++) apb(1'b0, 12'h020, 32'h0, st, er);
        apb(1'b0, 12'h024, 32'h0, b[31:0], er);
        apb(1'b0, 12'h028, 32'h0, b[63:32], er);
        apb(1'b0, 12'h02C, 32'h0, tg, er);
    endtask
    task automatic t_regs();
        logic [31:0] rd;
        logic        er;
        apb(1'b0, 12'h004, 32'h0, rd, er);
        cmp32(rd, 32'(DW_T));
        apb(1'b0, 12'h000, 32'h0, rd, er);
        cmp32(rd, 32'h0000_0000);
        apb(1'b0, 12'h00C, 32'h0, rd, er);
        cmp32({rd[30:0], er}, 32'h0000_0001);
        $display("register test done");
    endtask
    // upper and lower half of a present root entry, then of an absent one
    task automatic t_scalable();
        logic [127:0] e;
        logic [31:0]  st, tg;
        logic [63:0]  b, x;
        logic [7:0]   dfn;
        for (int i = 0; i < 4; i++) begin
            dfn = (i % 2 == 0) ? 8'h85 : 8'h12;
            e = u_mem.root_ent[i / 2];
            decode(e, {24'h0, dfn}, 32'h0000_0011, st, b, tg);
            cmp32(st & 32'h0000_0003, (i < 2) ? 32'h0 : 32'h1);
            cmp32({31'h0, fault}, 32'(i >= 2));
            x = {dfn[7] ? e[127:76] : e[63:12], 12'h000} & ((64'h1 << HAW_T) - 64'h1);
            x = x | {52'h0, dfn, 4'h0};
            if (i < 2) cmp32(b[31:0], x[31:0]);
            if (i < 2) cmp32(b[63:32], x[63:32]);
        end
        $display("scalable root test done");
    endtask
    // present context without and with pasid, then an absent one
    task automatic t_context();
        logic [31:0] st, tg;
        logic [63:0] b;
        decode(u_mem.ctx_ent[0], 32'h0000_0000, 32'h0000_0030, st, b, tg);
        cmp32(st & 32'h0000_0023, 32'h0000_0000);
        cmp32(tg, 32'h0000_00EF);
        decode(u_mem.ctx_ent[0], 32'h0000_0100, 32'h0000_0030, st, b, tg);
        cmp32(st & 32'h0000_0023, 32'h0000_0003);
        decode(u_mem.ctx_ent[1], 32'h0000_0000, 32'h0000_0030, st, b, tg);
        cmp32(st & 32'h0000_0023, 32'h0000_0022);
        cmp32(tg, 32'h0000_0000);
        $display("context test done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // reset for four cycles, then the scenarios
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_scalable();
        t_context();
        conclude();
    end
endmodule
